// ==== rtl/bsf_status_core.sv ====
// flags word, alarm and status bits, error code and fixed read words
// assumes measurements arrive already scaled to the selected unit system
`timescale 1ns/100ps
module bsf_status_core
#(
   parameter logic [63:0] DEFINED_UNIMPL_MASK = 64'h0
)
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // command port from the bus front end
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic cmd_write_in,
   input wire logic cmd_size_ok_in,
   input wire logic cmd_busy_in,
   input wire logic cmd_overflow_in,
   input wire logic cmd_fault_in,
   output logic rsp_valid_out,
   output logic [15:0] rsp_data_out,
   // flash load and configuration words
   input wire logic cfg_load_strobe_in,
   input wire logic cfg_load_ok_in,
   input wire logic [15:0] cfg_design_volt_in,
   input wire logic [15:0] cfg_spec_info_in,
   input wire logic [15:0] cfg_cap_mah_in,
   input wire logic [15:0] cfg_cap_mwh_in,
   input wire logic [15:0] cfg_cycle_count_in,
   input wire logic [15:0] cfg_cycle_thr_in,
   input wire logic [7:0] cfg_fc_clear_pct_in,
   input wire logic [7:0] cfg_batt_low_pct_in,
   // flash save of the cycle count
   output logic flash_wr_out,
   output logic [7:0] flash_wr_addr_out,
   output logic [15:0] flash_wr_data_out,
   // charge state
   input wire logic charging_in,
   input wire logic overcharge_in,
   input wire logic prim_term_in,
   input wire logic chg_param_bad_in,
   input wire logic nonchg_mah_tick_in,
   input wire logic removed_mah_tick_in,
   // temperature and voltage
   input wire logic [15:0] temp_in,
   input wire logic [15:0] max_temp_in,
   input wire logic [15:0] pack_volt_in,
   input wire logic [15:0] term_volt_in,
   input wire logic signed [15:0] current_in,
   input wire logic cell_undervoltage_flag_in,
   input wire logic below_first_end_of_discharge_threshold_in,
   input wire logic current_below_overload_in,
   // capacity and time, in the units that capacity mode selects
   input wire logic capacity_mode_in,
   input wire logic [15:0] charge_left_in,
   input wire logic [15:0] capacity_alarm_threshold_in,
   input wire logic [15:0] runtime_alarm_threshold_in,
   input wire logic [15:0] averaged_time_until_empty_in,
   input wire logic [7:0] charge_percentage_in,
   // flags word
   output logic [15:0] battery_flags_word_out
);
   import bsf_pkg::*;

   // classify a command into its error code
   function automatic logic [2:0] bsf_classify
   (
      input logic [7:0] code,
      input logic wr,
      input logic size_ok,
      input logic busy,
      input logic ovf,
      input logic fault
   );
      logic rsv;
      logic ro;
      rsv = (code >= CMD_RSV1_LO && code <= CMD_RSV1_HI) ||
            (code > CMD_STD_LAST && code != CMD_MFG_PACK &&
             !(code >= CMD_MFG_CELL_LO && code <= CMD_MFG_CELL_HI));
      ro = (code >= CMD_FLAGS_WORD && code <= CMD_SPEC_INFO);
      if (busy)
         return ERR_BUSY;
      else if (rsv)
         return ERR_RESERVED;
      else if (code <= CMD_MFG_CELL_HI && DEFINED_UNIMPL_MASK[code[5:0]])
         return ERR_UNSUPPORTED;
      else if (wr && ro)
         return ERR_ACCESS_DENIED;
      else if (wr && !size_ok)
         return ERR_BAD_SIZE;
      else if (ovf)
         return ERR_OVERFLOW;
      else if (fault)
         return ERR_UNKNOWN;
      else
         return ERR_OK;
   endfunction

   // captured configuration
   logic [15:0] cfg_volt;
   logic [15:0] cfg_spec;
   logic [15:0] cfg_cap_mah;
   logic [15:0] cfg_cap_mwh;
   logic [7:0] cfg_fc_clear;
   logic [7:0] cfg_batt_low;
   logic initialized;
   // cycle counter results
   logic [15:0] cycle_count;
   logic cycle_save;

   // flash image of the fixed words
   bsf_cfg_image u_cfg
   (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .load_strobe_in(cfg_load_strobe_in),
      .load_ok_in(cfg_load_ok_in),
      .volt_in(cfg_design_volt_in),
      .spec_in(cfg_spec_info_in),
      .cap_mah_in(cfg_cap_mah_in),
      .cap_mwh_in(cfg_cap_mwh_in),
      .fc_clear_pct_in(cfg_fc_clear_pct_in),
      .batt_low_pct_in(cfg_batt_low_pct_in),
      .volt_out(cfg_volt),
      .spec_out(cfg_spec),
      .cap_mah_out(cfg_cap_mah),
      .cap_mwh_out(cfg_cap_mwh),
      .fc_clear_pct_out(cfg_fc_clear),
      .batt_low_pct_out(cfg_batt_low),
      .initialized_out(initialized)
   );

   // cycle count with flash save requests
   bsf_cycle_counter u_cyc
   (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .load_in(cfg_load_strobe_in && cfg_load_ok_in),
      .load_value_in(cfg_cycle_count_in),
      .threshold_in(cfg_cycle_thr_in),
      .removed_mah_tick_in(removed_mah_tick_in),
      .count_out(cycle_count),
      .save_out(cycle_save)
   );

   // flag registers
   logic over_chg_q;
   logic term_chg_q;
   logic over_temp_q;
   logic term_dis_q;
   logic cap_alarm_q;
   logic time_alarm_q;
   logic discharging_q;
   logic full_chg_q;
   logic full_dis_q;
   logic [2:0] err_q;
   logic [1:0] nonchg_mah_q; // mAh of non-charge since charging stopped
   logic [15:0] charge_left_prev_q; // last sample, to see charging rises
   logic [15:0] atte_prev_q;

   // set and clear conditions
   wire oc_set = charging_in && overcharge_in;
   wire oc_clr = !charging_in && (nonchg_mah_q >= OVERCHG_CLEAR_MAH);
   wire tc_cond = chg_param_bad_in || prim_term_in;
   wire td_set = (pack_volt_in <= term_volt_in) || cell_undervoltage_flag_in;
   wire td_clr = (pack_volt_in > term_volt_in) && (current_in > 16'sh0000) &&
                 !cell_undervoltage_flag_in;
   wire ca_set = charge_left_in < capacity_alarm_threshold_in;
   wire ca_clr = (capacity_alarm_threshold_in < charge_left_in) ||
                 (charging_in && charge_left_in > charge_left_prev_q);
   wire ta_set = averaged_time_until_empty_in < runtime_alarm_threshold_in;
   wire ta_clr = (runtime_alarm_threshold_in < averaged_time_until_empty_in) ||
                 (charging_in && averaged_time_until_empty_in > atte_prev_q);
   wire fc_set = prim_term_in || overcharge_in;
   wire fc_clr = charge_percentage_in < cfg_fc_clear;
   wire fd_set = (below_first_end_of_discharge_threshold_in &&
                  current_below_overload_in) ||
                 (charge_percentage_in < cfg_batt_low);
   wire fd_clr = charge_percentage_in >= FULL_DIS_CLEAR_PCT;

   // command decode
   wire [2:0] cmd_err = bsf_classify(cmd_code_in, cmd_write_in,
      cmd_size_ok_in, cmd_busy_in, cmd_overflow_in, cmd_fault_in);
   wire rd_here = cmd_valid_in && !cmd_write_in && !cmd_busy_in &&
                  cmd_code_in >= CMD_FLAGS_WORD &&
                  cmd_code_in <= CMD_SPEC_INFO;
   // design capacity in the unit system that capacity mode picks
   wire [15:0] design_cap = capacity_mode_in ? cfg_cap_mwh : cfg_cap_mah;

   // the flags word as it stands now
   wire [15:0] flags_now = {over_chg_q, term_chg_q, 1'b0, over_temp_q,
      term_dis_q, 1'b0, cap_alarm_q, time_alarm_q, initialized,
      discharging_q, full_chg_q, full_dis_q, 1'b0, err_q};

   // read data selection
   logic [15:0] rd_word;
   always_comb
   begin
      case (cmd_code_in)
         CMD_FLAGS_WORD: rd_word = flags_now;
         CMD_CYCLE_COUNT: rd_word = cycle_count;
         CMD_DESIGN_CAP: rd_word = design_cap;
         CMD_DESIGN_VOLT: rd_word = cfg_volt;
         CMD_SPEC_INFO: rd_word = cfg_spec;
         default: rd_word = WORD_RESET;
      endcase
   end

   // non-charge charge accumulator for the overcharge release
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         nonchg_mah_q <= 2'h0;
      else if (charging_in)
         nonchg_mah_q <= 2'h0; // continuity broken by charging
      else if (nonchg_mah_tick_in && nonchg_mah_q < OVERCHG_CLEAR_MAH)
         nonchg_mah_q <= nonchg_mah_q + 2'h1;
   end

   // previous samples used to see charging raise a value
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         charge_left_prev_q <= WORD_RESET;
         atte_prev_q <= WORD_RESET;
      end
      else
      begin
         charge_left_prev_q <= charge_left_in;
         atte_prev_q <= averaged_time_until_empty_in;
      end
   end

   // alarm bits; a set wins over a clear in the same cycle
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         over_chg_q <= 1'b0;
         term_chg_q <= 1'b0;
         over_temp_q <= 1'b0;
         term_dis_q <= 1'b0;
         cap_alarm_q <= 1'b0;
         time_alarm_q <= 1'b0;
      end
      else
      begin
         if (oc_set)
            over_chg_q <= 1'b1;
         else if (oc_clr)
            over_chg_q <= 1'b0;
         term_chg_q <= tc_cond;
         over_temp_q <= (temp_in >= max_temp_in);
         if (td_set)
            term_dis_q <= 1'b1;
         else if (td_clr)
            term_dis_q <= 1'b0;
         if (ca_set)
            cap_alarm_q <= 1'b1;
         else if (ca_clr)
            cap_alarm_q <= 1'b0;
         if (ta_set)
            time_alarm_q <= 1'b1;
         else if (ta_clr)
            time_alarm_q <= 1'b0;
      end
   end

   // status bits and error code
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         discharging_q <= 1'b0;
         full_chg_q <= 1'b0;
         full_dis_q <= 1'b0;
         err_q <= ERR_OK;
      end
      else
      begin
         discharging_q <= !charging_in;
         if (fc_set)
            full_chg_q <= 1'b1;
         else if (fc_clr)
            full_chg_q <= 1'b0;
         if (fd_set)
            full_dis_q <= 1'b1;
         else if (fd_clr)
            full_dis_q <= 1'b0;
         if (cmd_valid_in)
            err_q <= cmd_err;
      end
   end

   // registered outputs: read answer, flags word, flash save
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rsp_valid_out <= 1'b0;
         rsp_data_out <= WORD_RESET;
         battery_flags_word_out <= WORD_RESET;
         flash_wr_out <= 1'b0;
         flash_wr_addr_out <= FLASH_CYCLE_COUNT_ADDR;
         flash_wr_data_out <= WORD_RESET;
      end
      else
      begin
         rsp_valid_out <= rd_here;
         if (rd_here)
            rsp_data_out <= rd_word;
         battery_flags_word_out <= flags_now;
         flash_wr_out <= cycle_save;
         if (cycle_save)
            flash_wr_data_out <= cycle_count;
      end
   end

   // checks on the behaviour above
   AST_OVERTEMP: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (temp_in >= max_temp_in) |=> over_temp_q ##1
      battery_flags_word_out[BIT_OVER_TEMP])
      else $error("over-temperature alarm not raised");

   AST_DISCHG: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      !charging_in |=> discharging_q)
      else $error("discharging bit missing while not charging");

   AST_OC_HOLD: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (over_chg_q && charging_in) |=> over_chg_q)
      else $error("overcharge alarm cleared during charge");

   AST_FD_CLEAR: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (!fd_set && charge_percentage_in >= FULL_DIS_CLEAR_PCT) |=> !full_dis_q)
      else $error("fully-discharged bit kept at twenty percent");

   AST_TD_SET: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      cell_undervoltage_flag_in |=> term_dis_q)
      else $error("discharge alarm missing on undervoltage");

   AST_ERR_WR_RO: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (cmd_valid_in && cmd_write_in && !cmd_busy_in &&
       cmd_code_in == CMD_CYCLE_COUNT) |=> ##1
      battery_flags_word_out[ERR_MSB:0] == ERR_ACCESS_DENIED)
      else $error("write to read-only code not denied");

   AST_RSP: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (rd_here && cmd_code_in == CMD_CYCLE_COUNT) |=>
      rsp_valid_out && rsp_data_out == $past(cycle_count))
      else $error("cycle count read answer wrong");

   AST_CYC_SAT: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (cycle_count == CYCLE_COUNT_MAX && !cfg_load_strobe_in) |=>
      cycle_count == CYCLE_COUNT_MAX)
      else $error("cycle count wrapped past maximum");

   AST_SAVE: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      cycle_save |=> flash_wr_out && flash_wr_data_out == $past(cycle_count))
      else $error("cycle count not saved after update");

   AST_CAP_MODE: assert property (@(posedge clk_sys_in)
      disable iff (!reset_n_in)
      (rd_here && cmd_code_in == CMD_DESIGN_CAP && capacity_mode_in) |=>
      rsp_data_out == $past(cfg_cap_mwh))
      else $error("design capacity ignores capacity mode");

endmodule

// ==== rtl/bsf_pkg.sv ====
// constants shared by the battery status flag logic and its helpers
// assumes one system clock and command codes arriving from a bus front end
package bsf_pkg;

   // command codes served here
   localparam logic [7:0] CMD_FLAGS_WORD = 8'h16;
   localparam logic [7:0] CMD_CYCLE_COUNT = 8'h17;
   localparam logic [7:0] CMD_DESIGN_CAP = 8'h18;
   localparam logic [7:0] CMD_DESIGN_VOLT = 8'h19;
   localparam logic [7:0] CMD_SPEC_INFO = 8'h1A;

   // command code map used for error classification
   localparam logic [7:0] CMD_STD_LAST = 8'h23;
   localparam logic [7:0] CMD_RSV1_LO = 8'h1D;
   localparam logic [7:0] CMD_RSV1_HI = 8'h1F;
   localparam logic [7:0] CMD_MFG_PACK = 8'h2F;
   localparam logic [7:0] CMD_MFG_CELL_LO = 8'h3C;
   localparam logic [7:0] CMD_MFG_CELL_HI = 8'h3F;

   // flag positions inside the flags word
   localparam int BIT_OVER_CHARGED = 15;
   localparam int BIT_TERM_CHARGE = 14;
   localparam int BIT_OVER_TEMP = 12;
   localparam int BIT_TERM_DISCHARGE = 11;
   localparam int BIT_CAP_ALARM = 9;
   localparam int BIT_TIME_ALARM = 8;
   localparam int BIT_INITIALIZED = 7;
   localparam int BIT_DISCHARGING = 6;
   localparam int BIT_FULLY_CHARGED = 5;
   localparam int BIT_FULLY_DISCHARGED = 4;
   localparam int ERR_MSB = 2;

   // error codes in the low bits of the flags word
   localparam logic [2:0] ERR_OK = 3'h0;
   localparam logic [2:0] ERR_BUSY = 3'h1;
   localparam logic [2:0] ERR_RESERVED = 3'h2;
   localparam logic [2:0] ERR_UNSUPPORTED = 3'h3;
   localparam logic [2:0] ERR_ACCESS_DENIED = 3'h4;
   localparam logic [2:0] ERR_OVERFLOW = 3'h5;
   localparam logic [2:0] ERR_BAD_SIZE = 3'h6;
   localparam logic [2:0] ERR_UNKNOWN = 3'h7;

   // thresholds and limits
   localparam logic [1:0] OVERCHG_CLEAR_MAH = 2'h2;
   localparam logic [7:0] FULL_DIS_CLEAR_PCT = 8'h14;
   localparam logic [15:0] CYCLE_COUNT_MAX = 16'hFFFF;

   // flash location of the saved cycle count (low byte address)
   localparam logic [7:0] FLASH_CYCLE_COUNT_ADDR = 8'h0C;

   // reset values
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage

// ==== rtl/bsf_cfg_image.sv ====
// holds the configuration words captured from flash at full or partial reset
// assumes a one-cycle load strobe with a validity qualifier from the loader
`timescale 1ns/100ps
module bsf_cfg_image
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // flash load event
   input wire logic load_strobe_in,
   input wire logic load_ok_in,
   // raw flash words
   input wire logic [15:0] volt_in,
   input wire logic [15:0] spec_in,
   input wire logic [15:0] cap_mah_in,
   input wire logic [15:0] cap_mwh_in,
   input wire logic [7:0] fc_clear_pct_in,
   input wire logic [7:0] batt_low_pct_in,
   // captured image
   output logic [15:0] volt_out,
   output logic [15:0] spec_out,
   output logic [15:0] cap_mah_out,
   output logic [15:0] cap_mwh_out,
   output logic [7:0] fc_clear_pct_out,
   output logic [7:0] batt_low_pct_out,
   output logic initialized_out
);
   import bsf_pkg::*;

   // capture on a good load; a bad load keeps old words but drops init
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         volt_out <= WORD_RESET;
         spec_out <= WORD_RESET;
         cap_mah_out <= WORD_RESET;
         cap_mwh_out <= WORD_RESET;
         fc_clear_pct_out <= BYTE_RESET;
         batt_low_pct_out <= BYTE_RESET;
         initialized_out <= 1'b0;
      end
      else if (load_strobe_in)
      begin
         initialized_out <= load_ok_in;
         if (load_ok_in)
         begin
            volt_out <= volt_in;
            spec_out <= spec_in;
            cap_mah_out <= cap_mah_in;
            cap_mwh_out <= cap_mwh_in;
            fc_clear_pct_out <= fc_clear_pct_in;
            batt_low_pct_out <= batt_low_pct_in;
         end
      end
   end

endmodule

// ==== rtl/bsf_cycle_counter.sv ====
// counts charge cycles from removed-charge ticks and requests flash save
// assumes one tick per mAh removed and a preload from flash at reset
`timescale 1ns/100ps
module bsf_cycle_counter
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // preload and configuration
   input wire logic load_in,
   input wire logic [15:0] load_value_in,
   input wire logic [15:0] threshold_in,
   // charge removal
   input wire logic removed_mah_tick_in,
   // results
   output logic [15:0] count_out,
   output logic save_out
);
   import bsf_pkg::*;

   logic [15:0] acc_q; // mAh removed since the last count
   wire [15:0] acc_inc = acc_q + 16'h0001;
   wire thr_hit = removed_mah_tick_in && (acc_inc >= threshold_in);
   wire at_max = (count_out == CYCLE_COUNT_MAX);

   // accumulate charge, step the count, pulse a save after each step
   always_ff @(posedge clk_sys_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         acc_q <= WORD_RESET;
         count_out <= WORD_RESET;
         save_out <= 1'b0;
      end
      else
      begin
         save_out <= 1'b0;
         if (load_in)
         begin
            count_out <= load_value_in;
            acc_q <= WORD_RESET;
         end
         else if (thr_hit)
         begin
            acc_q <= WORD_RESET;
            if (!at_max)
            begin
               count_out <= count_out + 16'h0001;
               save_out <= 1'b1;
            end
         end
         else if (removed_mah_tick_in)
            acc_q <= acc_inc;
      end
   end

endmodule

// ==== testbench/bsf_host_model.sv ====
// host model: issues one command per call on the command port
// assumes calls start just after a falling clock edge
`timescale 1ns/100ps
module bsf_host_model
(
   // clock
   input wire logic clk_sys_in,
   // command port: qualifiers are {write, size ok, busy, overflow, fault}
   output logic cmd_valid_out,
   output logic [7:0] cmd_code_out,
   output logic [4:0] cmd_qual_out
);
   // idle bus at time zero
   initial
   begin
      cmd_valid_out = 1'b0;
      cmd_code_out = 8'h00;
      cmd_qual_out = 5'h00;
   end
   // one-cycle command, taken at the next rising edge
   task automatic issue(input logic [7:0] code, input logic [4:0] q);
      cmd_valid_out = 1'b1;
      cmd_code_out = code;
      cmd_qual_out = q;
      @(negedge clk_sys_in);
      cmd_valid_out = 1'b0;
      // idle lines show the inverse so stale values never look valid
      cmd_code_out = ~code;
      cmd_qual_out = ~q;
   endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the status flag core
// assumes the host model and the design files are compiled first
`timescale 1ns/100ps
module tb;
   import bsf_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t got %h expected %h", $time, a, b); end end
   logic clk_sys_in = 1'b0, reset_n_in = 1'b0;
   logic cv, rv, stb, ok, fw, chg, ovc, pt, pb, nt, rt, uv, edv, ovl, mode;
   logic [7:0] cc, fa, fc, bl, pct;
   logic [4:0] cq;
   logic [15:0] rd_w, vo, sp, mah, mwh, cnt, thr, fd, tmp, tmx, pv, tv;
   logic [15:0] cl, cth, rth, tte, flags, exp_w, last_save;
   logic signed [15:0] cur;
   logic [15:0] expq[$];
   int mismatches = 0, check_count = 0, cycles = 0, seed = 65321, saves = 0;
   // error table: code, qualifiers, expected error code
   logic [7:0] ec [8] = '{8'h17, 8'h1D, 8'h05, 8'h0F, 8'h1D, 8'h10, 8'h10,
      8'h40};
   logic [4:0] eq [8] = '{5'h18, 5'h00, 5'h00, 5'h10, 5'h04, 5'h02, 5'h01,
      5'h00};
   logic [2:0] ee [8] = '{ERR_ACCESS_DENIED, ERR_RESERVED, ERR_UNSUPPORTED,
      ERR_BAD_SIZE, ERR_BUSY, ERR_OVERFLOW, ERR_UNKNOWN, ERR_RESERVED};
   always #25 clk_sys_in = ~clk_sys_in;
   bsf_host_model host (.clk_sys_in(clk_sys_in), .cmd_valid_out(cv),
      .cmd_code_out(cc), .cmd_qual_out(cq));
   // code 0x05 stands for a defined but unimplemented command
   bsf_status_core #(.DEFINED_UNIMPL_MASK(64'h20)) dut (
      .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cmd_valid_in(cv),
      .cmd_code_in(cc), .cmd_write_in(cq[4]), .cmd_size_ok_in(cq[3]),
      .cmd_busy_in(cq[2]), .cmd_overflow_in(cq[1]), .cmd_fault_in(cq[0]),
      .rsp_valid_out(rv), .rsp_data_out(rd_w), .cfg_load_strobe_in(stb),
      .cfg_load_ok_in(ok), .cfg_design_volt_in(vo), .cfg_spec_info_in(sp),
      .cfg_cap_mah_in(mah), .cfg_cap_mwh_in(mwh), .cfg_cycle_count_in(cnt),
      .cfg_cycle_thr_in(thr), .cfg_fc_clear_pct_in(fc),
      .cfg_batt_low_pct_in(bl), .flash_wr_out(fw), .flash_wr_addr_out(fa),
      .flash_wr_data_out(fd), .charging_in(chg), .overcharge_in(ovc),
      .prim_term_in(pt), .chg_param_bad_in(pb), .nonchg_mah_tick_in(nt),
      .removed_mah_tick_in(rt), .temp_in(tmp), .max_temp_in(tmx),
      .pack_volt_in(pv), .term_volt_in(tv), .current_in(cur),
      .cell_undervoltage_flag_in(uv),
      .below_first_end_of_discharge_threshold_in(edv),
      .current_below_overload_in(ovl), .capacity_mode_in(mode),
      .charge_left_in(cl), .capacity_alarm_threshold_in(cth),
      .runtime_alarm_threshold_in(rth), .averaged_time_until_empty_in(tte),
      .charge_percentage_in(pct), .battery_flags_word_out(flags));
   // verdict and end of run
   task automatic complete_run();
      if (mismatches == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // answers are compared against the oldest note in arrival order
   always @(negedge clk_sys_in)
   begin
      if (rv === 1'b1)
      begin
         exp_w = (expq.size() > 0) ? expq.pop_front() : 16'hDEAD;
         `CHK(rd_w, exp_w)
      end
      if (fw === 1'b1)
      begin
         saves++;
         last_save = fd;
         `CHK(fa, FLASH_CYCLE_COUNT_ADDR)
      end
   end
   // hang guard
   always @(posedge clk_sys_in)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         mismatches++;
         complete_run();
      end
   end
   task automatic rd(input logic [7:0] code, input logic [15:0] e);
      expq.push_back(e);
      host.issue(code, 5'h00);
      @(negedge clk_sys_in);
   endtask
   // flag bit check once the two register stages have settled
   task automatic fl(input int b, input logic v);
      repeat (3) @(negedge clk_sys_in);
      `CHK(flags[b], v)
   endtask
   task automatic load(input logic good);
      ok = good;
      stb = 1'b1;
      @(negedge clk_sys_in);
      stb = 1'b0;
   endtask
   task automatic pulse_rt(input int n);
      repeat (n)
      begin
         rt = 1'b1;
         @(negedge clk_sys_in);
         rt = 1'b0;
         @(negedge clk_sys_in);
      end
   endtask
   task automatic pulse_nt();
      nt = 1'b1;
      @(negedge clk_sys_in);
      nt = 1'b0;
   endtask
   // main sequence
   initial
   begin
      {stb, ok, chg, ovc, pt, pb, nt, rt, uv, edv, ovl, mode} = 12'h000;
      vo = 16'($random(seed));
      sp = {8'h00, 8'($random(seed))}; // scale nibbles kept zero
      mah = 16'($random(seed));
      mwh = 16'($random(seed));
      cnt = 16'($random(seed)) & 16'h7FFF;
      {thr, fc, bl, pct, cur} = {16'h0003, 8'h5A, 8'h0A, 8'h32, 16'sh0000};
      {tmp, tmx, pv, tv} = {16'h0BB8, 16'h0C80, 16'h2EE0, 16'h2328};
      {cl, cth, rth, tte} = {16'h0400, 16'h0100, 16'h000A, 16'h0040};
      repeat (6) @(negedge clk_sys_in);
      reset_n_in = 1'b1;
      fl(BIT_INITIALIZED, 1'b0);
      load(1'b1);
      fl(BIT_INITIALIZED, 1'b1);
      rd(CMD_DESIGN_VOLT, vo);
      rd(CMD_SPEC_INFO, sp);
      rd(CMD_DESIGN_CAP, mah);
      mode = 1'b1;
      rd(CMD_DESIGN_CAP, mwh);
      pulse_rt(3);
      rd(CMD_CYCLE_COUNT, cnt + 16'h0001);
      `CHK(last_save, cnt + 16'h0001)
      load(1'b0);
      fl(BIT_INITIALIZED, 1'b0);
      rd(CMD_DESIGN_VOLT, vo);
      cnt = 16'hFFFE;
      load(1'b1);
      pulse_rt(3);
      pulse_rt(3);
      rd(CMD_CYCLE_COUNT, CYCLE_COUNT_MAX);
      `CHK(saves, 2)
      for (int i = 0; i < 8; i++)
      begin
         host.issue(ec[i], eq[i]);
         @(negedge clk_sys_in);
         `CHK(flags[2:0], ee[i])
      end
      host.issue(8'h0F, 5'h18);
      @(negedge clk_sys_in);
      `CHK(flags[2:0], ERR_OK)
      fl(BIT_DISCHARGING, 1'b1);
      chg = 1'b1;
      fl(BIT_DISCHARGING, 1'b0);
      ovc = 1'b1;
      fl(BIT_OVER_CHARGED, 1'b1);
      `CHK(flags[BIT_FULLY_CHARGED], 1'b1)
      {ovc, chg} = 2'b00;
      pulse_nt();
      fl(BIT_OVER_CHARGED, 1'b1);
      `CHK(flags[BIT_FULLY_CHARGED], 1'b0)
      pulse_nt();
      fl(BIT_OVER_CHARGED, 1'b0);
      pb = 1'b1;
      fl(BIT_TERM_CHARGE, 1'b1);
      pb = 1'b0;
      fl(BIT_TERM_CHARGE, 1'b0);
      pt = 1'b1;
      fl(BIT_TERM_CHARGE, 1'b1);
      `CHK(flags[BIT_FULLY_CHARGED], 1'b1)
      pt = 1'b0;
      fl(BIT_FULLY_CHARGED, 1'b0);
      tmp = tmx;
      fl(BIT_OVER_TEMP, 1'b1);
      tmp = tmx - 16'h0001;
      fl(BIT_OVER_TEMP, 1'b0);
      uv = 1'b1;
      fl(BIT_TERM_DISCHARGE, 1'b1);
      uv = 1'b0;
      fl(BIT_TERM_DISCHARGE, 1'b1);
      cur = 16'sh0064;
      fl(BIT_TERM_DISCHARGE, 1'b0);
      cl = cth - 16'h0001;
      fl(BIT_CAP_ALARM, 1'b1);
      cth = cl - 16'h0001;
      fl(BIT_CAP_ALARM, 1'b0);
      tte = rth - 16'h0001;
      fl(BIT_TIME_ALARM, 1'b1);
      rth = tte - 16'h0001;
      fl(BIT_TIME_ALARM, 1'b0);
      pct = bl - 8'h01;
      fl(BIT_FULLY_DISCHARGED, 1'b1);
      pct = FULL_DIS_CLEAR_PCT - 8'h01;
      fl(BIT_FULLY_DISCHARGED, 1'b1);
      pct = FULL_DIS_CLEAR_PCT;
      fl(BIT_FULLY_DISCHARGED, 1'b0);
      {edv, ovl} = 2'b11;
      fl(BIT_FULLY_DISCHARGED, 1'b1);
      {edv, ovl} = 2'b00;
      fl(BIT_FULLY_DISCHARGED, 1'b0);
      rd(CMD_FLAGS_WORD, 16'h00C0);
      `CHK({flags[13], flags[10], flags[3]}, 3'h0)
      complete_run();
   end
endmodule
